// file: unrp_read_port.sv
// unrp_read_port: top of the user nonvolatile byte read port
// Operation
// - content held as eight 128-bit banks
// - one byte per synchronous read access
// - upper three address bits pick bank
// - lower four address bits pick byte
// - no write or erase from core
// - readback via programming port or core
// assumes: core logic on core_clk_i drives rd_en_i/rd_addr_i; prog side already synchronous
`timescale 1ns/1ps
`default_nettype none
module unrp_read_port
	import unrp_pkg::*;
(
	input  wire logic                 core_clk_i,
	input  wire logic                 rst_b_i,
	input  wire logic                 rd_en_i,
	input  wire logic [ADDR_W-1:0]    rd_addr_i,
	output logic      [BYTE_W-1:0]    rd_data_o,
	output logic                      rd_valid_o,
	input  wire unrp_prog_s           prog_i,
	input  wire logic                 prog_rd_en_i,
	input  wire unrp_bank_t           prog_rd_bank_i,
	output logic [BANK_BITS-1:0]      prog_rd_data_o
);
	unrp_addr_s           addr_dec;
	unrp_bank_t           sel_bank;
	logic [BANK_BITS-1:0] bank_word;
	logic [BYTE_W-1:0]    byte_sel;
	logic [BYTE_W-1:0]    rd_data_r, rd_data_nxt;
	logic                 rd_valid_r, rd_valid_nxt;
	logic [BANK_BITS-1:0] prog_rd_r, prog_rd_nxt;

	// address split into bank and byte fields
	assign addr_dec = unrp_split(rd_addr_i);

	// programming readback borrows the bank mux; core read wins when both ask
	assign sel_bank = rd_en_i ? addr_dec.bank : prog_rd_bank_i;

	// store has only a programming write port, nothing from the core
	unrp_bank_store #(
		.NBANK(BANK_CNT)
	) u_store (
		.core_clk_i     (core_clk_i),
		.prog_i         (prog_i),
		.rd_bank_i      (sel_bank),
		.rd_bank_data_o (bank_word)
	);

	// byte pick inside the selected bank
	assign byte_sel = bank_word[addr_dec.idx*BYTE_W +: BYTE_W];

	// next values: capture on request, otherwise hold last byte
	always_comb begin
		rd_data_nxt  = rd_data_r;
		rd_valid_nxt = 1'b0;
		prog_rd_nxt  = prog_rd_r;
		if (rd_en_i) begin
			rd_data_nxt  = byte_sel;
			rd_valid_nxt = 1'b1;
		end else if (prog_rd_en_i) begin
			prog_rd_nxt = bank_word;
		end
	end

	// registered outputs, synchronous reset
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			rd_data_r  <= DATA_RST_VAL;
			rd_valid_r <= 1'b0;
			prog_rd_r  <= '0;
		end else begin
			rd_data_r  <= rd_data_nxt;
			rd_valid_r <= rd_valid_nxt;
			prog_rd_r  <= prog_rd_nxt;
		end
	end

	assign rd_data_o      = rd_data_r;
	assign rd_valid_o     = rd_valid_r;
	assign prog_rd_data_o = prog_rd_r;

	// reference fields cut straight from the address pins, so the checks
	// do not lean on the splitter or the bank mux that they watch
	unrp_bank_t           ref_bank;
	unrp_byte_t           ref_idx;
	logic [BANK_BITS-1:0] ref_word;
	logic [BYTE_W-1:0]    ref_byte;
	logic [BANK_CNT-1:0]  bank_seen_r, bank_seen_nxt;

	// reference byte, independent of the read path
	assign ref_bank = rd_addr_i[BANK_FLD_LSB +: BANK_FLD_W];
	assign ref_idx  = rd_addr_i[BYTE_FLD_LSB +: BYTE_FLD_W];
	assign ref_word = u_store.mem_r[ref_bank];
	assign ref_byte = ref_word[ref_idx*BYTE_W +: BYTE_W];

	// banks programmed since reset; an unprogrammed bank reads unknown
	// in simulation, so content checks on it would only raise false alarms
	always_comb begin
		bank_seen_nxt = bank_seen_r;
		if (prog_i.wr_en) begin
			bank_seen_nxt[prog_i.bank] = 1'b1;
		end
	end

	// cleared with the outputs although the array keeps its content;
	// the cost is that the content check idles until the next program
	always_ff @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			bank_seen_r <= '0;
		end else begin
			bank_seen_r <= bank_seen_nxt;
		end
	end

	// checks on the core read and programming paths, all on core_clk_i and
	// quiet while reset holds, except the reset check itself

	// a request returns the addressed byte exactly one cycle later
	rd_latency_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(rd_en_i && !prog_i.wr_en)
		|=> (rd_valid_o && (rd_data_o == $past(ref_byte))))
		else $error("read data not the addressed byte one cycle later");

	// without a request the last byte must stand
	rd_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		!rd_en_i
		|=> $stable(rd_data_o))
		else $error("read data changed without a new address");

	// valid only ever follows a request
	valid_pulse_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		rd_valid_o
		|-> $past(rd_en_i))
		else $error("valid without a request");

	// valid drops when no request was taken, one byte per access
	valid_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		!rd_en_i
		|=> !rd_valid_o)
		else $error("valid stands without a request");

	// bank comes from the upper address field
	bank_field_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		rd_en_i
		|-> (sel_bank == ref_bank))
		else $error("bank not from upper address bits");

	// byte index comes from the lower address field
	byte_field_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		rd_en_i
		|-> (addr_dec.idx == ref_idx))
		else $error("byte index not from lower address bits");

	// the mux path lands on the same byte as the reference
	// taken straight from the array
	byte_lane_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		rd_en_i
		|-> (byte_sel == ref_byte))
		else $error("byte lane differs from the addressed byte");

	// only the programming side may alter a bank; checked on the bank
	// the mux points at, once that bank holds known content
	no_core_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(!prog_i.wr_en && bank_seen_r[sel_bank])
		|=> (u_store.mem_r[$past(sel_bank)] == $past(bank_word)))
		else $error("bank content changed without programming");

	// a program writes the whole bank in one go
	prog_bank_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		prog_i.wr_en
		|=> (u_store.mem_r[$past(prog_i.bank)] == $past(prog_i.data)))
		else $error("whole bank not programmed");

	// programming readback returns the selected bank next cycle
	prog_readback_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(prog_rd_en_i && !rd_en_i)
		|=> (prog_rd_data_o == $past(bank_word)))
		else $error("programming readback wrong");

	// readback word stands until the next accepted readback
	readback_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		!(prog_rd_en_i && !rd_en_i)
		|=> $stable(prog_rd_data_o))
		else $error("readback word changed without a readback");

	// a core read in the same cycle wins; the readback is dropped
	core_wins_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(rd_en_i && prog_rd_en_i)
		|=> $stable(prog_rd_data_o))
		else $error("readback taken while core read was pending");

	// with the core idle the bank mux follows the programming side
	readback_mux_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		!rd_en_i
		|-> (sel_bank == prog_rd_bank_i))
		else $error("bank mux not on programming side");

	// reset clears every output register, the array is left alone
	reset_clear_a: assert property (@(posedge core_clk_i)
		!rst_b_i
		|=> (!rd_valid_o && (rd_data_o == DATA_RST_VAL) && (prog_rd_data_o == '0)))
		else $error("outputs not cleared by reset");

	// main scenarios the bench is meant to reach
	back_to_back_c: cover property (@(posedge core_clk_i) rd_en_i ##1 rd_en_i);
	prog_then_read_c: cover property (@(posedge core_clk_i) prog_i.wr_en ##1 rd_en_i);
	readback_c: cover property (@(posedge core_clk_i) prog_rd_en_i && !rd_en_i);
	core_wins_c: cover property (@(posedge core_clk_i) rd_en_i && prog_rd_en_i);
	reset_reread_c: cover property (@(posedge core_clk_i) $rose(rst_b_i) ##[1:4] rd_en_i);

endmodule
`default_nettype wire

// file: unrp_pkg.sv
// unrp_pkg: shared constants and carrier types for the user nonvolatile byte read port
// assumes: nothing beyond a SystemVerilog package-aware tool flow
package unrp_pkg;

	localparam int BANK_CNT      = 8;    // independently programmed banks
	localparam int BANK_BITS     = 128;  // bits per bank
	localparam int BYTE_W        = 8;
	localparam int BYTES_PER_BNK = BANK_BITS / BYTE_W;
	localparam int ADDR_W        = 7;
	localparam int BANK_FLD_W    = 3;    // upper address bits
	localparam int BYTE_FLD_W    = 4;    // lower address bits
	localparam int BANK_FLD_LSB  = 4;
	localparam int BYTE_FLD_LSB  = 0;
	localparam int READ_LAT_CYC  = 1;    // address sample to data valid
	localparam logic [7:0] DATA_RST_VAL = 8'h00;

	typedef logic [BANK_FLD_W-1:0] unrp_bank_t;
	typedef logic [BYTE_FLD_W-1:0] unrp_byte_t;

	// decoded read address
	typedef struct packed {
		unrp_bank_t bank;
		unrp_byte_t idx;
	} unrp_addr_s;

	// programming-port write (bank granular); readback request uses separate ports
	typedef struct packed {
		logic       wr_en;
		unrp_bank_t bank;
		logic [BANK_BITS-1:0] data;
	} unrp_prog_s;

	// split a 7-bit core address into bank and byte fields
	function automatic unrp_addr_s unrp_split(input logic [ADDR_W-1:0] a);
		unrp_addr_s s;
		s.bank = a[BANK_FLD_LSB +: BANK_FLD_W];
		s.idx  = a[BYTE_FLD_LSB +: BYTE_FLD_W];
		return s;
	endfunction

endpackage

// file: unrp_bank_store.sv
// unrp_bank_store: eight 128-bit banks, written whole from the programming side only
// assumes: prog port arrives already in core_clk_i domain; no core write path exists
`timescale 1ns/1ps
`default_nettype none
module unrp_bank_store
	import unrp_pkg::*;
#(
	parameter int NBANK = BANK_CNT
) (
	input  wire logic                 core_clk_i,
	input  wire unrp_prog_s           prog_i,
	input  wire unrp_bank_t           rd_bank_i,
	output logic [BANK_BITS-1:0]      rd_bank_data_o
);
	// contents are nonvolatile, so no reset touches the array
	logic [BANK_BITS-1:0] mem_r [NBANK];

	// whole-bank program, bank is the programming unit
	always_ff @(posedge core_clk_i) begin
		if (prog_i.wr_en) begin
			mem_r[prog_i.bank] <= prog_i.data;
		end
	end

	// both core and programming side read through here
	assign rd_bank_data_o = mem_r[rd_bank_i];

endmodule
`default_nettype wire

// file: unrp_core_model.sv
// unrp_core_model: core-side user logic issuing byte reads
// assumes: bench sets req/addr after a rising edge
`timescale 1ns/1ps
`default_nettype none
module unrp_core_model
	import unrp_pkg::*;
(
	input  wire logic              core_clk_i,
	input  wire logic              req_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	output logic                   rd_en_o = 1'b0,
	output logic      [ADDR_W-1:0] rd_addr_o = '0
);
	// launch on falling edge; idle address inverted so no stale copy looks valid
	always @(negedge core_clk_i) begin
		rd_en_o   <= req_i;
		rd_addr_o <= req_i ? addr_i : ~rd_addr_o;
	end
endmodule
`default_nettype wire

// file: test_user_nvm_byte_read_port.sv
// test_user_nvm_byte_read_port: self-checking bench for the byte read port
// assumes: unrp_pkg compiled first; core reads go through unrp_core_model
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin failures++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module test_user_nvm_byte_read_port
	import unrp_pkg::*;
;
	logic                 clk = 1'b0, rst_b = 1'b0, req = 1'b0, prd = 1'b0;
	logic [ADDR_W-1:0]    addr = '0;
	unrp_bank_t           pbank = '0;
	unrp_prog_s           prog = '0;
	logic                 rd_en, vld;
	logic [ADDR_W-1:0]    rd_addr;
	logic [BYTE_W-1:0]    rdat;
	logic [BANK_BITS-1:0] pdat;
	int                   failures = 0, n_tests = 0, cyc = 0;
	unrp_read_port u_unrp_read_port (.core_clk_i(clk), .rst_b_i(rst_b), .rd_en_i(rd_en),
		.rd_addr_i(rd_addr), .rd_data_o(rdat), .rd_valid_o(vld), .prog_i(prog),
		.prog_rd_en_i(prd), .prog_rd_bank_i(pbank), .prog_rd_data_o(pdat));
	unrp_core_model u_unrp_core_model (.core_clk_i(clk), .req_i(req), .addr_i(addr),
		.rd_en_o(rd_en), .rd_addr_o(rd_addr));
	// each byte carries its own address, so a wrong bank or byte shows
	function automatic logic [BANK_BITS-1:0] pat(input int b);
		for (int k = 0; k < 16; k++)
			pat[8*k +: 8] = {1'b1, 3'(b), 4'(k)};
	endfunction
	task automatic report_and_stop();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic wr(input unrp_bank_t b, input logic [BANK_BITS-1:0] d);
		@(negedge clk) prog <= '{1'b1, b, d};
		@(negedge clk) prog.wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] e);
		@(posedge clk) req <= 1'b1;
		addr <= a;
		@(posedge clk) req <= 1'b0;
		@(negedge clk) `CHK("byte", {1'b1, e}, {vld, rdat})
		@(negedge clk) `CHK("hold", {1'b0, e}, {vld, rdat})
	endtask
	task automatic rd2(input logic [ADDR_W-1:0] a, b);
		@(posedge clk) req <= 1'b1;
		addr <= a;
		@(posedge clk) addr <= b;
		@(negedge clk) `CHK("first", {2'b11, a}, {vld, rdat})
		@(posedge clk) req <= 1'b0;
		@(negedge clk) `CHK("second", {2'b11, b}, {vld, rdat})
	endtask
	task automatic pr(input unrp_bank_t b, input logic [BANK_BITS-1:0] e);
		@(negedge clk) prd <= 1'b1;
		pbank <= b;
		@(negedge clk) prd <= 1'b0;
		`CHK("readback", e, pdat)
	endtask
	// core read and readback in one cycle: core wins, readback word stands
	task automatic rdpr(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] e,
		input unrp_bank_t pb, input logic [BANK_BITS-1:0] old);
		@(posedge clk) req <= 1'b1;
		addr <= a;
		@(negedge clk) prd <= 1'b1;
		pbank <= pb;
		@(posedge clk) req <= 1'b0;
		@(negedge clk) prd <= 1'b0;
		`CHK("core wins", {1'b1, e, old}, {vld, rdat, pdat})
	endtask
	// reset in mid run: outputs clear, stored banks survive
	task automatic rst_mid(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] e);
		@(negedge clk) rst_b <= 1'b0;
		repeat (2) @(negedge clk);
		`CHK("mid reset", 137'h0, {vld, rdat, pdat})
		rst_b <= 1'b1;
		rd(a, e);
	endtask
	initial begin
		forever #50 clk = ~clk;
	end
	// hang guard; a full run needs under 1000 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			report_and_stop();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		@(negedge clk) `CHK("reset", 137'h0, {vld, rdat, pdat})
		rst_b <= 1'b1;
		$display("reset done");
		for (int b = 0; b < BANK_CNT; b++)
			wr(3'(b), pat(b));
		for (int a = 0; a < 128; a++)
			rd(7'(a), {1'b1, 7'(a)});
		$display("sweep done");
		rd2(7'h7F, 7'h00);
		$display("back to back done");
		pr(3'h5, pat(5));
		rdpr(7'h13, 8'h93, 3'h6, pat(5));
		$display("readback done");
		wr(3'h2, ~pat(2));
		rd(7'h2F, 8'h50);
		$display("rewrite done");
		rst_mid(7'h2F, 8'h50);
		$display("mid reset done");
		report_and_stop();
	end
endmodule
`default_nettype wire
